// ==== src/meas_cal_pkg.sv ====
// constants, offsets and types for the measurement and calibration command executor
package meas_cal_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_ADC     = 8'h0c;
  localparam logic [7:0] OFS_RSSI    = 8'h10;
  localparam logic [7:0] OFS_REG_SET = 8'h14;
  localparam logic [7:0] OFS_DEPTH   = 8'h18;
  localparam logic [7:0] OFS_TRIM    = 8'h1c;
  // control register field positions
  localparam int CTL_OP_EN      = 0;
  localparam int CTL_TX_EN      = 1;
  localparam int CTL_RX_EN      = 2;
  localparam int CTL_REG_EXT    = 3;
  localparam int CTL_SUPPLY_5V  = 4;
  localparam int CTL_CS_MCAL_LO = 8;
  localparam int CTL_CS_MCAL_HI = 12;
  localparam int CTL_GAIN_LO    = 16;
  localparam int CTL_GAIN_HI    = 19;
  localparam int CTL_DEPTH_LO   = 24;
  localparam int CTL_DEPTH_HI   = 31;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // command codes
  typedef enum logic [3:0] {
    CMD_MEAS_AMPL   = 4'h1,
    CMD_SQUELCH     = 4'h2,
    CMD_RESET_GAIN  = 4'h3,
    CMD_ADJ_REG     = 4'h4,
    CMD_CAL_DEPTH   = 4'h5,
    CMD_CAL_ANT     = 4'h6,
    CMD_MEAS_PHASE  = 4'h7,
    CMD_CLEAR_RSSI  = 4'h8,
    CMD_TRANSPARENT = 4'h9,
    CMD_CAL_CSENSE  = 4'ha,
    CMD_MEAS_CAP    = 4'hb
  } cmd_t;
  // timing, in ns and derived cycles at 25 MHz
  localparam int CLK_NS       = 40;
  localparam int AMPL_NS      = 25000;
  localparam int SQUELCH_NS   = 500000;
  localparam int REG_SETTLE_NS = 300000;
  localparam int REG_MAX_NS   = 5000000;
  localparam int DEPTH_NS     = 275000;
  localparam int ANT_NS       = 250000;
  localparam int CSCAL_NS     = 3000000;
  localparam int CAP_NS       = 250000;
  // longest times round down; run a bit short of the maximum
  localparam int MEAS_CYC     = AMPL_NS / CLK_NS - 1;
  localparam int SQUELCH_CYC  = SQUELCH_NS / CLK_NS - 1;
  localparam int SETTLE_CYC   = REG_SETTLE_NS / CLK_NS;
  localparam int DEPTH_CYC    = DEPTH_NS / CLK_NS - 1;
  localparam int ANT_CYC      = ANT_NS / CLK_NS - 1;
  localparam int CSCAL_CYC    = CSCAL_NS / CLK_NS - 1;
  localparam int CAP_CYC      = CAP_NS / CLK_NS - 1;
  // regulator codes in mV and steps
  localparam logic [12:0] REG_MAX_5V  = 13'd5100;
  localparam logic [12:0] REG_MAX_3V  = 13'd3400;
  localparam logic [12:0] REG_MIN_5V  = 13'd3900;
  localparam logic [12:0] REG_MIN_3V  = 13'd2400;
  localparam logic [12:0] REG_STEP_5V = 13'd120;
  localparam logic [12:0] REG_STEP_3V = 13'd100;
  localparam logic [12:0] REG_MARGIN  = 13'd250;
  // amplitude lsb in uVpp
  localparam int AMPL_LSB_UV = 13020;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_MEAS  = 6'b000010,
    ST_SETTLE = 6'b000100,
    ST_CHECK = 6'b001000,
    ST_TIMED = 6'b010000,
    ST_DONE  = 6'b100000
  } state_t;
endpackage : meas_cal_pkg

// ==== src/measure_calibrate_cmd_exec.sv ====
// measurement and calibration direct command executor with ahb-lite register slave
// What this block does
// - amplitude command enables tx and amplitude detector, absolute conversion, stores result
// - amplitude lsb is 13.02 mVpp; command finishes within 25 us
// - most commands need operation enable set and oscillator stable
// - only receive-gain reset, rssi clear and transparent mode may be chained
// - completion interrupt for measurements, regulator, depth and sensor calibration only
// - squelch needs tx and rx on, runs only while receiver inactive, 500 us
// - gain reset inits gain logic, aborts squelch, loads manual gain reduction
// - regulator adjust starts with rx and tx on and regulator at maximum
// - every 300 us compare rf supply to main, lower one step if short
// - regulator adjust stops at margin or minimum, within 5 ms
// - regulator adjust rejected when external regulated voltage is selected
// - depth calibration transmits, adapts toward target, reports result, within 275 us
// - antenna calibration trims parallel capacitors to resonance, within 250 us
// - phase command enables tx and phase detector, relative conversion, stores result
// - phase saturates ff below 30 deg, 00 above 150 deg, 90 deg mid-scale
// - rising receiver-active clears rssi and restarts peak-hold measurement
// - rssi clear zeroes rssi and restarts peak measurement while receiver active
// - transparent mode entered on next select rising edge, held while select high
// - capacitive calibration runs only with all manual bits zero, within 3 ms
// - capacitance measurement completes within 250 us
// - receiver-active is the enable gating rssi and gain control
`timescale 1ns/1ns
module measure_calibrate_cmd_exec (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_stable,
  input  wire logic        rx_active,
  input  wire logic        select_pin,
  input  wire logic [7:0]  adc_sample,
  input  wire logic [12:0] main_supply_mv,
  input  wire logic [12:0] rf_regulated_supply_mv,
  input  wire logic [3:0]  rssi_level,
  input  wire logic        trim_resonant,
  input  wire logic [7:0]  depth_measured,
  output logic             tx_enable,
  output logic             rx_enable,
  output logic             ampl_det_en,
  output logic             phase_det_en,
  output logic             adc_relative,
  output logic             cap_sense_en,
  output logic [7:0]       trim_capacitor_pins,
  output logic             transparent_mode,
  output logic             cmd_irq,
  output logic             chain_ok
);
  import meas_cal_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for inputs from outside this clock
  logic [1:0] osc_sync, rx_sync, sel_sync;
  logic       rx_q, sel_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      osc_sync <= 2'h0;
      rx_sync  <= 2'h0;
      sel_sync <= 2'h0;
      rx_q     <= 1'b0;
      sel_q    <= 1'b0;
    end
    else
    begin
      osc_sync <= {osc_sync[0], osc_stable};
      rx_sync  <= {rx_sync[0], rx_active};
      sel_sync <= {sel_sync[0], select_pin};
      rx_q     <= rx_sync[1];
      sel_q    <= sel_sync[1];
    end
  wire rx_on   = rx_sync[1];
  wire rx_rise = rx_on && !rx_q;
  wire sel_rise = sel_sync[1] && !sel_q;

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  logic [31:0] control;
  logic [7:0]  adc_result, depth_display, trim_sel;
  logic [3:0]  rssi;
  logic [12:0] reg_setting;
  logic [3:0]  manual_gain;
  logic        squelch_set, busy, trans_armed;
  logic [7:0]  wr_addr;
  logic        wr_pend, rd_sel;
  state_t      state;
  cmd_t        cmd;
  wire addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr;
    end
  wire cmd_wr = wr_pend && wr_addr == OFS_COMMAND;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      control <= CONTROL_RESET;
    else if (wr_pend && wr_addr == OFS_CONTROL)
      control <= hwdata;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      unique case (haddr)
        OFS_CONTROL: hrdata <= control;
        OFS_STATUS:  hrdata <= {24'h0, 1'b0, squelch_set, trans_armed, transparent_mode,
                                chain_ok, cmd_irq, busy, state == ST_IDLE};
        OFS_ADC:     hrdata <= {24'h0, adc_result};
        OFS_RSSI:    hrdata <= {28'h0, rssi};
        OFS_REG_SET: hrdata <= {19'h0, reg_setting};
        OFS_DEPTH:   hrdata <= {24'h0, depth_display};
        OFS_TRIM:    hrdata <= {24'h0, trim_sel};
        default:     hrdata <= 32'h0000_0000;
      endcase

  //////////////////////////////////////////////////////////////////////////////
  // acceptance
  wire       gate_ok  = control[CTL_OP_EN] && osc_sync[1];
  wire [3:0] new_cmd  = hwdata[3:0];
  logic      accept;
  always_comb
  begin
    accept = 1'b0;
    if (!busy)
      unique case (new_cmd)
        CMD_MEAS_AMPL, CMD_MEAS_PHASE, CMD_RESET_GAIN, CMD_CAL_DEPTH, CMD_CAL_ANT,
        CMD_CLEAR_RSSI, CMD_TRANSPARENT: accept = gate_ok;
        CMD_ADJ_REG:    accept = gate_ok && !control[CTL_REG_EXT];
        CMD_SQUELCH:    accept = control[CTL_TX_EN] && control[CTL_RX_EN];
        CMD_CAL_CSENSE: accept = control[CTL_CS_MCAL_HI:CTL_CS_MCAL_LO] == 5'h00;
        CMD_MEAS_CAP:   accept = 1'b1;
        default:        accept = 1'b0;
      endcase
  end
  wire start = cmd_wr && accept;
  // gain reset is also taken mid-squelch, since it must be able to abort it
  wire gain_rst = cmd_wr && new_cmd == CMD_RESET_GAIN && gate_ok
                  && (!busy || (state == ST_TIMED && cmd == CMD_SQUELCH));
  wire five_v = control[CTL_SUPPLY_5V];

  //////////////////////////////////////////////////////////////////////////////
  // sequencer, timed in device clock cycles
  logic [17:0] timer;
  logic [17:0] limit;
  always_comb
  begin
    limit = 18'(MEAS_CYC);
    unique case (cmd)
      CMD_SQUELCH:    limit = 18'(SQUELCH_CYC);
      CMD_CAL_DEPTH:  limit = 18'(DEPTH_CYC);
      CMD_CAL_ANT:    limit = 18'(ANT_CYC);
      CMD_CAL_CSENSE: limit = 18'(CSCAL_CYC);
      CMD_MEAS_CAP:   limit = 18'(CAP_CYC);
      default:        limit = 18'(MEAS_CYC);
    endcase
  end
  wire [12:0] reg_min  = five_v ? REG_MIN_5V : REG_MIN_3V;
  wire [12:0] reg_step = five_v ? REG_STEP_5V : REG_STEP_3V;
  wire margin_ok = 14'(rf_regulated_supply_mv) + 14'(REG_MARGIN) <= 14'(main_supply_mv);
  // squelch holds off while receiver active; its counter only runs when idle
  wire run_en = !(cmd == CMD_SQUELCH && rx_on);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state <= ST_IDLE;
      cmd   <= CMD_MEAS_AMPL;
      timer <= 18'h0;
    end
    else
      unique case (state)
        ST_IDLE:
          if (start)
          begin
            cmd   <= cmd_t'(new_cmd);
            timer <= 18'h0;
            unique case (new_cmd)
              CMD_ADJ_REG:                   state <= ST_SETTLE;
              CMD_RESET_GAIN, CMD_CLEAR_RSSI,
              CMD_TRANSPARENT:               state <= ST_IDLE;
              CMD_MEAS_AMPL, CMD_MEAS_PHASE: state <= ST_MEAS;
              default:                       state <= ST_TIMED;
            endcase
          end
        ST_MEAS, ST_TIMED:
          if (gain_rst)
            state <= ST_IDLE;
          else if (timer >= limit || (cmd == CMD_CAL_ANT && trim_resonant))
            state <= ST_DONE;
          else if (run_en)
            timer <= timer + 18'h1;
        ST_SETTLE:
          if (timer >= 18'(SETTLE_CYC - 1))
            state <= ST_CHECK;
          else
            timer <= timer + 18'h1;
        ST_CHECK:
        begin
          timer <= 18'h0;
          // stop at margin or floor; at most 10 steps, 11 intervals of 300 us, stay under 5 ms
          if (margin_ok || reg_setting <= reg_min)
            state <= ST_DONE;
          else
            state <= ST_SETTLE;
        end
        ST_DONE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  assign busy = state != ST_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // analog control outputs
  wire meas_a = state == ST_MEAS && cmd == CMD_MEAS_AMPL;
  wire meas_p = state == ST_MEAS && cmd == CMD_MEAS_PHASE;
  wire reg_on = state == ST_SETTLE || state == ST_CHECK;
  wire dep_on = state == ST_TIMED && cmd == CMD_CAL_DEPTH;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_enable    <= 1'b0;
      rx_enable    <= 1'b0;
      ampl_det_en  <= 1'b0;
      phase_det_en <= 1'b0;
      adc_relative <= 1'b0;
      cap_sense_en <= 1'b0;
    end
    else
    begin
      tx_enable    <= control[CTL_TX_EN] || meas_a || meas_p || reg_on || dep_on;
      rx_enable    <= control[CTL_RX_EN] || reg_on;
      ampl_det_en  <= meas_a;
      phase_det_en <= meas_p;
      adc_relative <= meas_p;
      cap_sense_en <= state == ST_TIMED && (cmd == CMD_MEAS_CAP || cmd == CMD_CAL_CSENSE);
    end

  //////////////////////////////////////////////////////////////////////////////
  // results: converter output, regulator, depth, trim
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      adc_result <= 8'h00;
    else if (state == ST_MEAS && timer >= limit)
      adc_result <= adc_sample;
    else if (state == ST_TIMED && cmd == CMD_MEAS_CAP && timer >= limit)
      adc_result <= adc_sample;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      reg_setting <= REG_MAX_3V;
    else if (start && new_cmd == CMD_ADJ_REG)
      reg_setting <= five_v ? REG_MAX_5V : REG_MAX_3V;
    else if (state == ST_CHECK && !margin_ok && reg_setting > reg_min)
      reg_setting <= (reg_setting - reg_step < reg_min) ? reg_min : reg_setting - reg_step;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      depth_display <= 8'h00;
    else if (dep_on && timer >= limit)
      depth_display <= depth_measured;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      trim_sel <= 8'h00;
    else if (start && new_cmd == CMD_CAL_ANT)
      trim_sel <= 8'h00;
    else if (state == ST_TIMED && cmd == CMD_CAL_ANT && !trim_resonant && timer[4:0] == 5'h1f)
      trim_sel <= trim_sel + 8'h01;
  assign trim_capacitor_pins = trim_sel;

  //////////////////////////////////////////////////////////////////////////////
  // gain, squelch and rssi logic
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      manual_gain <= 4'h0;
      squelch_set <= 1'b0;
    end
    else if (gain_rst)
    begin
      manual_gain <= control[CTL_GAIN_HI:CTL_GAIN_LO];
      squelch_set <= 1'b0;
    end
    else if (state == ST_TIMED && cmd == CMD_SQUELCH && timer >= limit)
      squelch_set <= 1'b1;
  // peak hold, gated by receiver-active; clears win over new peaks
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rssi <= 4'h0;
    else if (rx_rise || (start && new_cmd == CMD_CLEAR_RSSI) || gain_rst)
      rssi <= 4'h0;
    else if (rx_on && rssi_level > rssi)
      rssi <= rssi_level;

  //////////////////////////////////////////////////////////////////////////////
  // transparent mode, irq, chaining
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      trans_armed      <= 1'b0;
      transparent_mode <= 1'b0;
    end
    else
    begin
      if (start && new_cmd == CMD_TRANSPARENT)
        trans_armed <= 1'b1;
      else if (sel_rise)
        trans_armed <= 1'b0;
      if (sel_rise && trans_armed)
        transparent_mode <= 1'b1;
      else if (!sel_sync[1])
        transparent_mode <= 1'b0;
    end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cmd_irq  <= 1'b0;
      chain_ok <= 1'b1;
    end
    else
    begin
      cmd_irq  <= state == ST_DONE && cmd != CMD_SQUELCH && cmd != CMD_CAL_ANT;
      chain_ok <= !busy;
    end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_reject_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_wr && !accept && !busy) |=> state == ST_IDLE && !cmd_irq)
    else $error("rejected command changed state");
  a_reg_ext_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_wr && !busy && new_cmd == CMD_ADJ_REG && control[CTL_REG_EXT]) |=> state == ST_IDLE)
    else $error("regulator adjust accepted with external select");
  a_gate_needed: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_wr && !busy && new_cmd == CMD_MEAS_AMPL && !gate_ok) |=> state == ST_IDLE)
    else $error("amplitude accepted without enable");
  a_ampl_detector: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_MEAS && cmd == CMD_MEAS_AMPL) |=> ampl_det_en && tx_enable && !adc_relative)
    else $error("amplitude path not set");
  a_phase_relative: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_MEAS && cmd == CMD_MEAS_PHASE) |=> phase_det_en && adc_relative)
    else $error("phase path not set");
  a_meas_duration: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_IDLE && start && new_cmd == CMD_MEAS_AMPL) |=> ##[1:625] state == ST_DONE)
    else $error("amplitude overran");
  a_irq_squelch: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_DONE && cmd == CMD_SQUELCH) |=> !cmd_irq)
    else $error("squelch raised irq");
  a_irq_measure: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_DONE && cmd == CMD_MEAS_PHASE) |=> cmd_irq)
    else $error("phase irq missing");
  a_rssi_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_rise |=> rssi == 4'h0)
    else $error("rssi not cleared on receiver start");
  a_reg_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    reg_on |-> reg_setting >= reg_min)
    else $error("regulator below minimum");
  a_chain_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) |=> !chain_ok)
    else $error("chaining allowed while busy");
endmodule : measure_calibrate_cmd_exec

// ==== bench/analog_host_model.sv ====
// analog front end and host select line model facing the command executor
`timescale 1ns/1ns
module analog_host_model (
  input  wire logic       frame_go,
  input  wire logic [3:0] rssi_set,
  input  wire logic [7:0] trim_code,
  output logic            select_pin,
  output logic [12:0]     main_supply_mv,
  output logic [12:0]     rf_regulated_supply_mv,
  output logic [3:0]      rssi_level,
  output logic            trim_resonant,
  output logic [7:0]      depth_measured
);
  logic link_clk = 1'b0;
  initial select_pin = 1'b0;
  initial
  begin
    forever #160 link_clk = ~link_clk;
  end
  // select rises only on a link edge after the host opens a frame, and stays high for it
  always @(posedge link_clk) select_pin <= frame_go;
  // rf supply already 600 mV under main, so one settle interval is enough
  assign main_supply_mv         = 13'd3600;
  assign rf_regulated_supply_mv = 13'd3000;
  assign rssi_level             = rssi_set;
  assign trim_resonant          = (trim_code != 8'h00);
  assign depth_measured         = 8'h40;
endmodule : analog_host_model

// ==== bench/measure_calibrate_cmd_exec_tb_top.sv ====
// self-checking bench for the measurement and calibration command executor
`timescale 1ns/1ns
module measure_calibrate_cmd_exec_tb_top;
  import meas_cal_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        osc_stable = 1'b0;
  logic        rx_active = 1'b0;
  logic [7:0]  adc_sample = 8'h00;
  logic        frame_go = 1'b0;
  logic [3:0]  rssi_set = 4'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, select_pin, trim_resonant, tx_enable, rx_enable;
  logic        ampl_det_en, phase_det_en, adc_relative, cap_sense_en, transparent_mode;
  logic        cmd_irq, chain_ok;
  logic [12:0] main_mv, rf_mv;
  logic [3:0]  rssi_level;
  logic [7:0]  depth_measured, trim_capacitor_pins;
  logic [6:0]  snap;
  int          errors = 0;
  int          compares = 0;
  int          seed;
  initial
  begin
    forever #20 hclk = ~hclk;
  end
  measure_calibrate_cmd_exec u_measure_calibrate_cmd_exec (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_stable(osc_stable), .rx_active(rx_active), .select_pin(select_pin), .adc_sample(adc_sample),
    .main_supply_mv(main_mv), .rf_regulated_supply_mv(rf_mv), .rssi_level(rssi_level),
    .trim_resonant(trim_resonant), .depth_measured(depth_measured), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .ampl_det_en(ampl_det_en), .phase_det_en(phase_det_en),
    .adc_relative(adc_relative), .cap_sense_en(cap_sense_en), .trim_capacitor_pins(trim_capacitor_pins),
    .transparent_mode(transparent_mode), .cmd_irq(cmd_irq), .chain_ok(chain_ok));
  analog_host_model u_analog_host_model (.frame_go(frame_go), .rssi_set(rssi_set),
    .trim_code(trim_capacitor_pins), .select_pin(select_pin), .main_supply_mv(main_mv),
    .rf_regulated_supply_mv(rf_mv), .rssi_level(rssi_level), .trim_resonant(trim_resonant),
    .depth_measured(depth_measured));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address phase held until hready, then data phase held until hready again
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  // issue a command, snapshot the outputs three cycles in, wait for the completion pulse
  task run(input cmd_t c, input int lim, input logic irq_exp);
    int   n;
    logic seen;
    seen = 1'b0;
    bus(1'b1, OFS_COMMAND, {28'h0, c}, rd);
    repeat (3) @(posedge hclk);
    #1 snap = {cap_sense_en, tx_enable, rx_enable, ampl_det_en, phase_det_en, adc_relative, chain_ok};
    for (n = 3; n < lim && !seen; n++)
    begin
      @(posedge hclk);
      #1 seen = (cmd_irq === 1'b1);
    end
    chk("cmd_irq", {31'h0, irq_exp}, {31'h0, seen});
  endtask : run
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #4000000;
    errors++;
    results;
  end
  initial
  begin
    seed = $urandom(32'h757bd055);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk("chain_ok", 1, chain_ok);
    chk("hresp", 0, hresp);
    chk("tx_enable", 0, tx_enable);
    @(posedge hclk);
    osc_stable <= 1'b1;
    wr(OFS_CONTROL, 32'h0000_0002); // tx only, operation disabled
    run(CMD_MEAS_AMPL, 700, 1'b0);
    chk("idle", 1, snap[0]);
    bus(1'b0, OFS_ADC, 0, rd);
    chk("adc", 0, rd);
    wr(OFS_CONTROL, 32'h0000_0003);
    // random converter samples through both measurement kinds
    for (int i = 0; i < 4; i++)
    begin
      @(posedge hclk);
      adc_sample <= 8'($urandom);
      run(i[0] ? CMD_MEAS_PHASE : CMD_MEAS_AMPL, 630, 1'b1);
      chk("meas_outputs", i[0] ? 7'b0100110 : 7'b0101000, snap);
      bus(1'b0, OFS_ADC, 0, rd);
      chk("adc", {24'h0, adc_sample}, rd);
    end
    @(posedge hclk);
    osc_stable <= 1'b0;
    repeat (4) @(posedge hclk);
    run(CMD_MEAS_PHASE, 700, 1'b0);
    chk("idle", 1, snap[0]);
    @(posedge hclk);
    osc_stable <= 1'b1;
    repeat (4) @(posedge hclk);
    wr(OFS_CONTROL, 32'h0000_000f); // external regulator selected
    run(CMD_ADJ_REG, 700, 1'b0);
    chk("idle", 1, snap[0]);
    wr(OFS_CONTROL, 32'h0000_0007);
    run(CMD_ADJ_REG, 125000, 1'b1);
    chk("reg_outputs", 7'b0110000, snap);
    bus(1'b0, OFS_REG_SET, 0, rd);
    chk("reg_mv", {19'h0, REG_MAX_3V}, rd);
    run(CMD_SQUELCH, 12500, 1'b0);
    chk("squelch_busy", 0, snap[0]);
    // the done state lasts one cycle and chain_ok follows one cycle later
    repeat (2) @(posedge hclk);
    #1 chk("chain_ok", 1, chain_ok);
    bus(1'b0, OFS_STATUS, 0, rd);
    chk("status", 32'h49, rd);
    run(CMD_RESET_GAIN, 700, 1'b0);
    chk("chain_ok", 1, snap[0]);
    bus(1'b0, OFS_STATUS, 0, rd);
    chk("status", 32'h09, rd);
    // gain reset in mid-squelch aborts it
    run(CMD_SQUELCH, 40, 1'b0);
    run(CMD_RESET_GAIN, 10, 1'b0);
    chk("abort", 1, snap[0]);
    run(CMD_CAL_DEPTH, 6900, 1'b1);
    bus(1'b0, OFS_DEPTH, 0, rd);
    chk("depth", 32'h40, rd);
    run(CMD_CAL_ANT, 6250, 1'b0);
    chk("trim_nonzero", 1, trim_capacitor_pins != 8'h00);
    chk("chain_ok", 1, chain_ok);
    // manual sensor calibration set, so the calibration is rejected; capacitance measurement runs with tx and rx off
    wr(OFS_CONTROL, 32'h0000_0101);
    run(CMD_CAL_CSENSE, 700, 1'b0);
    chk("idle", 1, snap[0]);
    run(CMD_MEAS_CAP, 6300, 1'b1);
    chk("cap_outputs", 7'b1000000, snap);
    // peak hold, then clear while the receiver stays active
    @(posedge hclk);
    rssi_set  <= 4'h5;
    rx_active <= 1'b1;
    repeat (10) @(posedge hclk);
    rssi_set <= 4'h3;
    repeat (10) @(posedge hclk);
    bus(1'b0, OFS_RSSI, 0, rd);
    chk("rssi_peak", 32'h5, rd);
    run(CMD_CLEAR_RSSI, 700, 1'b0);
    bus(1'b0, OFS_RSSI, 0, rd);
    chk("rssi_clear", 32'h3, rd);
    run(CMD_TRANSPARENT, 10, 1'b0);
    frame_go <= 1'b1;
    repeat (30) @(posedge hclk);
    #1 chk("transparent", 1, transparent_mode);
    frame_go <= 1'b0;
    repeat (30) @(posedge hclk);
    #1 chk("transparent", 0, transparent_mode);
    results;
  end
endmodule : measure_calibrate_cmd_exec_tb_top
